/* src/adc_readout.sv */
// Device-side readout: master clock sync, conversion pacing, frame shift-out
// Functional notes
// - Serial output is released (high impedance) whenever chip select is high.
// - Two-entry result store; unread overflow makes data ready pulse every second period.
// - A sync falling edge after the first, off the conversion period boundary, sets the resync fault flag.
// - Sync realigns the period counter once, then acts as a continuous check, never as a conversion start.
// - A partially clocked frame leaves the result unread; it is sent again.
`timescale 1ns/1ps
`default_nettype none
module adc_readout
    import adc_readout_pkg::*;
#(
    parameter int unsigned CHANNELS  = NUM_CHANNELS,
    parameter int unsigned WBITS     = WORD_BITS,
    parameter int unsigned CONV_MCLK = CONV_PERIOD_MCLK
) (
    // Clock, reset, enable
    input  wire logic                   core_clk,
    input  wire logic                   rstn,
    input  wire logic                   clk_en,
    // Pins from the host
    input  wire logic                   master_clock_in,
    input  wire logic                   sync_reset_n,
    input  wire logic                   spi_sclk,
    input  wire logic                   spi_cs_n,
    // Conversion results from the modulator side
    input  wire logic [CHANNELS*WBITS-1:0] conv_data,
    // Pins to the host
    output logic                        spi_dout,
    output logic                        spi_dout_oe_n,
    output logic                        data_ready_n,
    // Status
    output logic                        resync_fault_flag,
    input  wire logic                   resync_fault_clear
);
    localparam int unsigned FWIDTH = CHANNELS * WBITS;
    localparam int unsigned FBITS  = (CHANNELS + 2) * WBITS;

    logic       rst_meta;
    logic       rst_n;
    logic [1:0] mclk_s;
    logic [1:0] sync_s;
    logic [1:0] sclk_s;
    logic [1:0] cs_s;
    logic       mclk_d;
    logic       sync_d;
    logic       sclk_d;
    logic       mclk_rise;
    logic       sync_edge;
    logic       sync_fall;
    logic       sclk_rise;
    logic       sclk_fall;
    logic       cs_n;
    logic [MCLK_CNT_W-1:0] mclk_cnt;
    logic       period_end;
    logic       conv_phase;
    logic       sync_seen;
    frame_state_t state;
    frame_state_t next_state;
    logic [FBITS-1:0]        shreg;
    logic [FRAME_CNT_W-1:0]  bit_cnt;
    logic [15:0]             status_word;
    logic                    frame_loaded;
    logic                    ovf_seen;

    sample_fifo_if #(.WIDTH(FWIDTH)) fifo ();

    sample_fifo #(.WIDTH(FWIDTH), .DEPTH(FIFO_DEPTH)) u_store (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .clk_en   (clk_en),
        .fifo     (fifo)
    );

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // Pin synchronisers; stage 0 feeds only stage 1
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mclk_s <= 2'h0;
            sync_s <= 2'h3;
            sclk_s <= 2'h0;
            cs_s   <= 2'h3;
            mclk_d <= 1'b0;
            sync_d <= 1'b1;
            sclk_d <= 1'b0;
        end else if (clk_en) begin
            mclk_s <= {mclk_s[0], master_clock_in};
            sync_s <= {sync_s[0], sync_reset_n};
            sclk_s <= {sclk_s[0], spi_sclk};
            cs_s   <= {cs_s[0], spi_cs_n};
            mclk_d <= mclk_s[1];
            sync_d <= sync_s[1];
            sclk_d <= sclk_s[1];
        end
    end

    assign mclk_rise = mclk_s[1] && !mclk_d;
    assign sync_edge = sync_s[1] != sync_d;
    assign sync_fall = sync_edge && !sync_s[1];
    assign sclk_rise = sclk_s[1] && !sclk_d;
    assign sclk_fall = !sclk_s[1] && sclk_d;
    assign cs_n      = cs_s[1];
    assign period_end = mclk_rise && (mclk_cnt == MCLK_CNT_W'(CONV_MCLK - 1));

    // Conversion period counter; a sync falling edge realigns it once
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mclk_cnt  <= '0;
            sync_seen <= 1'b0;
        end else if (clk_en) begin
            if (sync_fall && !sync_seen) begin
                mclk_cnt  <= '0;
                sync_seen <= 1'b1;
            end else if (period_end) begin
                mclk_cnt <= '0;
            end else if (mclk_rise) begin
                mclk_cnt <= mclk_cnt + MCLK_CNT_W'(1);
            end
        end
    end

    // Aligned sync edges land on a period boundary; others only flag, no restart
    assign conv_phase = (mclk_cnt == '0);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            resync_fault_flag <= 1'b0;
        end else if (clk_en) begin
            // Strobe release edge carries no timing; only the falling edge is checked
            if (sync_fall && sync_seen && !conv_phase) begin
                resync_fault_flag <= 1'b1;
            end else if (resync_fault_clear) begin
                resync_fault_flag <= 1'b0;
            end
        end
    end

    // New results enter the store each period; overflow drops oldest
    assign fifo.push      = period_end;
    assign fifo.push_data = conv_data;
    assign fifo.pop       = (state == FR_DONE) && cs_n && frame_loaded;

    always_comb begin
        status_word = STATUS_RESET;
        status_word[STATUS_FAULT_BIT] = resync_fault_flag;
        status_word[STATUS_OVF_BIT]   = ovf_seen;
    end

    // Overflow lasts one cycle; keep it until a whole frame has been read
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ovf_seen <= 1'b0;
        end else if (clk_en) begin
            if (fifo.overflow) begin
                ovf_seen <= 1'b1;
            end else if (fifo.pop) begin
                ovf_seen <= 1'b0;
            end
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            FR_IDLE:  if (!cs_n) next_state = FR_SHIFT;
            FR_SHIFT: begin
                if (cs_n) begin
                    next_state = FR_IDLE;
                end else if (bit_cnt == FRAME_CNT_W'(FBITS)) begin
                    next_state = FR_DONE;
                end
            end
            FR_DONE:  if (cs_n) next_state = FR_IDLE;
            default:  next_state = FR_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= FR_IDLE;
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    // Frame shifter: status word, channel words, trailing zero word
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            shreg        <= '0;
            bit_cnt      <= '0;
            frame_loaded <= 1'b0;
        end else if (clk_en) begin
            if (state == FR_IDLE && !cs_n) begin
                shreg        <= {status_word, {(WBITS-16){1'b0}}, fifo.head_data,
                                 {WBITS{1'b0}}};
                bit_cnt      <= '0;
                frame_loaded <= fifo.not_empty;
            end else if (state == FR_SHIFT && sclk_fall && bit_cnt != FRAME_CNT_W'(FBITS)) begin
                shreg <= {shreg[FBITS-2:0], 1'b0};
            end
            if (state == FR_SHIFT && sclk_rise && bit_cnt != FRAME_CNT_W'(FBITS)) begin
                bit_cnt <= bit_cnt + FRAME_CNT_W'(1);
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            spi_dout      <= 1'b0;
            spi_dout_oe_n <= 1'b1;
        end else if (clk_en) begin
            spi_dout      <= shreg[FBITS-1];
            spi_dout_oe_n <= cs_n || state == FR_IDLE;
        end
    end

    // Ready falls at period end; under overflow it toggles, so it falls every second period
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            data_ready_n <= 1'b1;
        end else if (clk_en) begin
            if (period_end && fifo.overflow && !data_ready_n) begin
                data_ready_n <= 1'b1;
            end else if (period_end) begin
                data_ready_n <= 1'b0;
            end else if (state == FR_IDLE && !cs_n) begin
                data_ready_n <= 1'b1;
            end
        end
    end

    property p_oe_follows_cs;
        @(posedge core_clk) disable iff (!rst_n) clk_en && cs_n |=> spi_dout_oe_n;
    endproperty
    a_oe_follows_cs: assert property (p_oe_follows_cs)
        else $error("output driven while deselected");

    property p_fault_set;
        @(posedge core_clk) disable iff (!rst_n)
        clk_en && sync_fall && sync_seen && !conv_phase |=> resync_fault_flag;
    endproperty
    a_fault_set: assert property (p_fault_set)
        else $error("resync fault not raised");

    property p_fault_hold;
        @(posedge core_clk) disable iff (!rst_n)
        resync_fault_flag && clk_en && !resync_fault_clear |=> resync_fault_flag;
    endproperty
    a_fault_hold: assert property (p_fault_hold)
        else $error("resync fault lost");

    property p_partial_no_pop;
        @(posedge core_clk) disable iff (!rst_n) fifo.pop |-> bit_cnt == FRAME_CNT_W'(FBITS);
    endproperty
    a_partial_no_pop: assert property (p_partial_no_pop)
        else $error("result dropped on short frame");

    property p_push_period;
        @(posedge core_clk) disable iff (!rst_n) fifo.push |-> mclk_rise;
    endproperty
    a_push_period: assert property (p_push_period)
        else $error("push off period boundary");

    // A later sync edge must leave the conversion counter running as it was
    property p_sync_no_restart;
        @(posedge core_clk) disable iff (!rst_n)
        clk_en && sync_fall && sync_seen && !mclk_rise |=> $stable(mclk_cnt);
    endproperty
    a_sync_no_restart: assert property (p_sync_no_restart)
        else $error("sync edge restarted conversion");

    sequence s_full_push;
        clk_en && period_end && fifo.overflow;
    endsequence
    property p_ovf_ready_rise;
        @(posedge core_clk) disable iff (!rst_n) s_full_push ##0 !data_ready_n |=> data_ready_n;
    endproperty
    a_ovf_ready_rise: assert property (p_ovf_ready_rise)
        else $error("ready not toggled on overflow");
endmodule : adc_readout
`default_nettype wire

/* src/adc_readout_pkg.sv */
// Shared constants and types for the shared-bus ADC readout block
package adc_readout_pkg;
    localparam int unsigned CORE_CLK_MHZ     = 100;
    localparam int unsigned NUM_CHANNELS     = 4;
    localparam int unsigned WORD_BITS        = 24;
    localparam int unsigned FIFO_DEPTH       = 2;
    localparam int unsigned CONV_PERIOD_MCLK = 1024;
    localparam int unsigned FRAME_WORDS      = NUM_CHANNELS + 2;
    localparam int unsigned FRAME_BITS       = FRAME_WORDS * WORD_BITS;
    localparam int unsigned FRAME_CNT_W      = $clog2(FRAME_BITS + 1);
    localparam int unsigned MCLK_CNT_W       = 16;
    localparam int unsigned STATUS_FAULT_BIT = 15;
    localparam int unsigned STATUS_OVF_BIT   = 14;
    localparam logic [15:0] STATUS_RESET     = 16'h0000;
    localparam logic [1:0]  FILL_RESET       = 2'h0;

    typedef enum logic [2:0] {
        FR_IDLE  = 3'b001,
        FR_SHIFT = 3'b010,
        FR_DONE  = 3'b100
    } frame_state_t;
endpackage : adc_readout_pkg

/* src/sample_fifo_if.sv */
// Carrier between the readout core and the two-entry result store
`timescale 1ns/1ps
`default_nettype none
interface sample_fifo_if #(parameter int unsigned WIDTH = 96);
    logic             push;
    logic [WIDTH-1:0] push_data;
    logic             pop;
    logic [WIDTH-1:0] head_data;
    logic             not_empty;
    logic             overflow;
    modport store (input push, push_data, pop, output head_data, not_empty, overflow);
    modport core  (output push, push_data, pop, input head_data, not_empty, overflow);
endinterface : sample_fifo_if
`default_nettype wire

/* src/sample_fifo.sv */
// Two-entry conversion result store; a push when full drops the oldest result
`timescale 1ns/1ps
`default_nettype none
module sample_fifo
    import adc_readout_pkg::*;
#(
    parameter int unsigned WIDTH = 96,
    parameter int unsigned DEPTH = FIFO_DEPTH
) (
    // Clocking
    input  wire logic   core_clk,
    input  wire logic   rst_n,
    input  wire logic   clk_en,
    // Core side
    sample_fifo_if.store fifo
);
    localparam int unsigned IDX_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [1:0]       fill;
    logic [IDX_W-1:0] tail_idx;

    // Last occupied slot once the shift has run
    assign tail_idx = IDX_W'(fill - 2'h1);

    assign fifo.head_data = mem[0];
    assign fifo.not_empty = (fill != FILL_RESET);
    assign fifo.overflow  = fifo.push && !fifo.pop && (fill == 2'(DEPTH));

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fill <= FILL_RESET;
        end else if (clk_en) begin
            if (fifo.push && !fifo.pop && fill != 2'(DEPTH)) begin
                fill <= fill + 2'h1;
            end else if (fifo.pop && !fifo.push && fill != FILL_RESET) begin
                fill <= fill - 2'h1;
            end
        end
    end

    // Storage shifts toward index 0; overflow discards the oldest entry
    always_ff @(posedge core_clk) begin
        if (clk_en) begin
            if (fifo.push) begin
                if (fifo.pop || fill == 2'(DEPTH)) begin
                    for (int i = 0; i < DEPTH - 1; i++) begin
                        mem[i] <= mem[i+1];
                    end
                    // Pop and push together keep the fill, so the new entry takes the tail
                    mem[tail_idx] <= fifo.push_data;
                end else begin
                    mem[fill[0:0]] <= fifo.push_data;
                end
            end else if (fifo.pop) begin
                for (int i = 0; i < DEPTH - 1; i++) begin
                    mem[i] <= mem[i+1];
                end
            end
        end
    end
endmodule : sample_fifo
`default_nettype wire

/* verification/host_spi_model.sv */
// Host side: master clock, sync strobe and SPI frame reader
`timescale 1ns/1ps
`default_nettype none
module host_spi_model (
    // Pacing
    input  wire logic core_clk,
    // Pins to the device
    output logic      master_clock_in,
    output logic      sync_reset_n,
    output logic      spi_sclk,
    output logic      spi_cs_n,
    // Shared output line
    input  wire logic spi_dout,
    input  wire logic spi_dout_oe_n
);
    logic last = 1'b0;
    logic line;

    // Released line shows the inverse of its last level, never a stale copy
    assign line = spi_dout_oe_n ? ~last : spi_dout;

    always @(posedge core_clk) begin
        if (!spi_dout_oe_n) last <= spi_dout;
    end

    initial begin
        sync_reset_n = 1'b1;
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        master_clock_in = 1'b0;
        forever #80 master_clock_in = ~master_clock_in;
    end

    task automatic pause(input int n);
        repeat (n) @(negedge core_clk);
    endtask : pause

    // First sync realigns the conversion counter; later ones are only a check
    task automatic strobe_sync();
        sync_reset_n = 1'b0;
        pause(8);
        sync_reset_n = 1'b1;
    endtask : strobe_sync

    // 80 ns link clock: 4 core cycles a half, still within the synchroniser's reach
    task automatic read_frame(input int nbits, output logic [143:0] got);
        got = '0;
        spi_cs_n = 1'b0;
        pause(16);
        for (int i = 0; i < nbits; i++) begin
            got = {got[142:0], line};
            spi_sclk = 1'b1;
            pause(4);
            spi_sclk = 1'b0;
            pause(4);
        end
        pause(8);
        spi_cs_n = 1'b1;
        pause(16);
    endtask : read_frame
endmodule : host_spi_model
`default_nettype wire

/* verification/tb_multi_adc_shared_spi_readout.sv */
// Self-checking bench for the shared-bus ADC readout block
`timescale 1ns/1ps
`default_nettype none
module tb_multi_adc_shared_spi_readout;
    import adc_readout_pkg::*;
    // Shorter period than the example ratio of 1024 keeps the run brief
    localparam int unsigned CONV = 256;
    localparam logic [95:0] DATA_A = 96'ha1b2c3_d4e5f6_071829_3a4b5c;
    localparam logic [95:0] DATA_B = 96'h5a5a5a_a5a5a5_123456_fedcba;
    localparam logic [95:0] DATA_C = 96'h800001_7ffffe_00ff00_ff00ff;
    logic         core_clk;
    logic         rstn;
    logic         clk_en;
    logic         resync_fault_clear;
    logic [95:0]  conv_data;
    logic         master_clock_in;
    logic         sync_reset_n;
    logic         spi_sclk;
    logic         spi_cs_n;
    logic         spi_dout;
    logic         spi_dout_oe_n;
    logic         data_ready_n;
    logic         resync_fault_flag;
    logic [143:0] got;
    int           errors;
    int           n_tests;
    int           falls;

    adc_readout #(.CONV_MCLK(CONV)) DUT (
        .core_clk(core_clk), .rstn(rstn), .clk_en(clk_en),
        .master_clock_in(master_clock_in), .sync_reset_n(sync_reset_n),
        .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .conv_data(conv_data),
        .spi_dout(spi_dout), .spi_dout_oe_n(spi_dout_oe_n),
        .data_ready_n(data_ready_n), .resync_fault_flag(resync_fault_flag),
        .resync_fault_clear(resync_fault_clear)
    );

    host_spi_model host (
        .core_clk(core_clk), .master_clock_in(master_clock_in),
        .sync_reset_n(sync_reset_n), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
        .spi_dout(spi_dout), .spi_dout_oe_n(spi_dout_oe_n)
    );

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    always @(negedge data_ready_n) falls++;

    task automatic conclude();
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : conclude

    task automatic chk(input string name, input logic [143:0] exp, input logic [143:0] seen);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic wait_ready();
        int k;
        k = 0;
        while (data_ready_n !== 1'b0 && k < 6000) begin
            @(negedge core_clk);
            k++;
        end
        if (data_ready_n !== 1'b0) begin
            errors++;
            $display("ERROR data_ready_n expected 0 seen %b", data_ready_n);
            conclude();
        end
    endtask : wait_ready

    initial begin
        errors = 0;
        n_tests = 0;
        falls = 0;
        rstn = 1'b0;
        clk_en = 1'b1;
        resync_fault_clear = 1'b0;
        conv_data = DATA_A;
        repeat (6) @(negedge core_clk);
        rstn = 1'b1;
        chk("oe_n at reset", 1, spi_dout_oe_n);
        chk("flag at reset", 0, resync_fault_flag);
        host.pause(8);
        host.strobe_sync();
        wait_ready();
        host.read_frame(144, got);
        chk("first frame", {24'h0, DATA_A, 24'h0}, got);
        chk("oe_n deselected", 1, spi_dout_oe_n);
        chk("flag after aligning sync", 0, resync_fault_flag);
        // Cut-short frame must not count as read
        conv_data = DATA_B;
        wait_ready();
        host.read_frame(50, got);
        host.read_frame(144, got);
        chk("repeat after partial", {24'h0, DATA_B, 24'h0}, got);
        // Leave results unread for six periods
        conv_data = DATA_C;
        falls = 0;
        host.pause(6 * CONV * 16);
        chk("ready falls unread", 3, falls);
        host.read_frame(144, got);
        chk("overflow frame", {24'h400000, DATA_C, 24'h0}, got);
        host.pause(100);
        host.strobe_sync();
        host.pause(20);
        chk("fault on stray sync", 1, resync_fault_flag);
        resync_fault_clear = 1'b1;
        host.pause(4);
        resync_fault_clear = 1'b0;
        host.pause(4);
        chk("fault cleared", 0, resync_fault_flag);
        host.pause(500);
        host.strobe_sync();
        host.pause(20);
        chk("fault set again", 1, resync_fault_flag);
        // Frozen core must ignore a clear
        clk_en = 1'b0;
        resync_fault_clear = 1'b1;
        host.pause(4);
        resync_fault_clear = 1'b0;
        clk_en = 1'b1;
        host.pause(4);
        chk("flag held while frozen", 1, resync_fault_flag);
        // Reset in mid-run
        rstn = 1'b0;
        host.pause(2);
        chk("flag in reset", 0, resync_fault_flag);
        chk("oe_n in reset", 1, spi_dout_oe_n);
        rstn = 1'b1;
        host.pause(2);
        chk("ready after reset", 1, data_ready_n);
        conclude();
    end
endmodule : tb_multi_adc_shared_spi_readout
`default_nettype wire
